// *** mpr_map.svh ***
// Register offsets, reset values and timing constants of the ramp block
`ifndef MPR_MAP_SVH
`define MPR_MAP_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define MPR_OFS_UPPER 5'h00
`define MPR_OFS_LOWER 5'h04
`define MPR_OFS_PRESET 5'h08
`define MPR_OFS_TRAVERSE 5'h0c
`define MPR_OFS_OUTPUT 5'h10
`define MPR_OFS_STATUS 5'h14

// ****************************************************
// Reset values (hundredths of a percent, tenths of a second)
// ****************************************************
`define MPR_RST_UPPER 16'sd10000
`define MPR_RST_LOWER -16'sd10000
`define MPR_RST_PRESET 16'sd0
`define MPR_RST_TRAVERSE 13'd100

// ****************************************************
// Value span and status field positions
// ****************************************************
`define MPR_PCT_MAX 16'sd30000
`define MPR_PCT_MIN -16'sd30000
`define MPR_FULL_SPAN 10000
`define MPR_TRAV_MAX 13'd6000
`define MPR_ST_AT_UPPER 0
`define MPR_ST_AT_LOWER 1
`define MPR_ST_RAMPING 2
`define MPR_ST_FORCED 3

// ****************************************************
// Timing: clock rate and one traverse unit of 0.1 s
// ****************************************************
`define MPR_CLK_HZ 125000000
`define MPR_TRAV_UNIT_MS 100
`define MPR_STEP_CYC ((`MPR_CLK_HZ / 1000 * `MPR_TRAV_UNIT_MS) / `MPR_FULL_SPAN)

`endif

// *** mpr_nv_store.sv ***
// Nonvolatile store model that keeps the ramp output across power loss
`timescale 1ns/1ps
module mpr_nv_store #(
  parameter logic [15:0] INIT_VALUE = 16'h0c35
) (
  input wire logic core_clk_in, // Control clock
  input wire logic save_in, // Save pulse from the ramp
  input wire logic [15:0] value_in, // Value to persist
  output logic [15:0] restore_value_out // Retained value
);
  // No reset on purpose: the store outlives a reset of the ramp
  logic [15:0] kept = INIT_VALUE;
  // Capture on every save pulse
  always @(posedge core_clk_in) begin
    if (save_in) begin
      kept <= value_in;
    end
  end
  assign restore_value_out = kept;
endmodule

// *** mpr_pkg.sv ***
// Types shared by the ramp block modules
package mpr_pkg;

  // Signed value in hundredths of a percent
  typedef logic signed [15:0] mpr_pct_t;

  // Traverse time in tenths of a second
  typedef logic [12:0] mpr_trav_t;

  // Working mode of the ramp, one-hot
  typedef enum logic [3:0] {
    MPR_HOLD = 4'b0001,
    MPR_UP = 4'b0010,
    MPR_DOWN = 4'b0100,
    MPR_FORCE = 4'b1000
  } mpr_mode_e;

endpackage

// *** mpr_step.sv ***
// Step pacer: one pulse per programmed interval while ramping
`timescale 1ns/1ps
module mpr_step
  import mpr_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input wire logic core_clk_in, // Control clock
  input wire logic rst_in, // Async reset, active high
  input wire logic run_in, // Ramp in progress
  input wire logic [CNT_W-1:0] interval_in, // Clocks per step, nonzero
  output logic step_out // One-cycle step pulse
);

  logic [CNT_W-1:0] count;

  initial begin
    if (CNT_W < 2 || CNT_W > 31) begin
      $error("mpr_step: CNT_W out of range");
    end
  end

  // Interval counter restarts whenever ramping stops, so a ramp that starts
  // from rest waits one full interval before its first step
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      step_out <= 1'b0;
    end else if (!run_in) begin
      count <= '0;
      step_out <= 1'b0;
    end else if (count >= interval_in - 1'b1) begin
      count <= '0;
      step_out <= 1'b1;
    end else begin
      count <= count + 1'b1;
      step_out <= 1'b0;
    end
  end

endmodule

// *** mpr_top.sv ***
// Motorised potentiometer ramp with Avalon-MM register slave
//
// Overview of operation
// - Force input makes output track preset level
// - Increment alone ramps up to upper limit
// - Decrement alone ramps down to lower limit
// - Both or neither request holds output
// - Traverse time spans full range, both directions
// - Above upper limit, ramp down to it
// - Below lower limit, ramp up to it
// - Output survives power loss, restored after reset
// - Limits and preset clamped to plus/minus 300%
`timescale 1ns/1ps
`include "mpr_map.svh"
module mpr_top
  import mpr_pkg::*;
#(
  parameter int STEP_CYC = `MPR_STEP_CYC,
  parameter int CNT_W = 24
) (
  input wire logic core_clk_in, // 125 MHz control clock
  input wire logic rst_in, // Async reset, active high
  input wire logic raise_in, // Increment request
  input wire logic lower_in, // Decrement request
  input wire logic force_in, // Force output to preset
  input wire logic [15:0] restore_value_in, // Retained value to resume
  input wire logic [4:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read strobe
  input wire logic avs_write_in, // Write strobe
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall
  output logic [15:0] value_out, // Ramped output, hundredths
  output logic save_out // Pulse: value changed, persist it
);

  // ****************************************************
  // Parameter checks and declarations
  // ****************************************************
  initial begin
    if (STEP_CYC < 1 || 64'(STEP_CYC) * 6000 >= (64'd1 << CNT_W)) begin
      $error("mpr_top: STEP_CYC does not fit CNT_W");
    end
  end

  mpr_pct_t upper;
  mpr_pct_t lower;
  mpr_pct_t preset;
  mpr_trav_t trav;
  mpr_pct_t out_val;
  mpr_pct_t target;
  mpr_pct_t next_out;
  mpr_mode_e mode;
  logic restore_pend;
  logic ack;
  logic step;
  logic ramping;
  logic [CNT_W-1:0] interval;

  // Clamp a signed word into the documented span
  function automatic mpr_pct_t pct_clamp(input mpr_pct_t v);
    if (v > `MPR_PCT_MAX) begin
      return `MPR_PCT_MAX;
    end else if (v < `MPR_PCT_MIN) begin
      return `MPR_PCT_MIN;
    end
    return v;
  endfunction

  // Merge written byte lanes into the low half of a register
  function automatic mpr_pct_t lane_merge(input mpr_pct_t cur, input logic [31:0] wd,
                                          input logic [3:0] be);
    mpr_pct_t r;
    r = cur;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ****************************************************
  // Avalon-MM slave: one wait cycle on every access
  // ****************************************************
  logic access;
  logic wr_go;
  assign access = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = access & ~ack;
  assign wr_go = avs_write_in & ack;

  // Acknowledge the cycle after a request is seen
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  // Read data latched in the wait cycle; unmapped addresses read zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack) begin
      if (avs_address_in == `MPR_OFS_UPPER) begin
        avs_readdata_out <= {16'h0000, upper};
      end else if (avs_address_in == `MPR_OFS_LOWER) begin
        avs_readdata_out <= {16'h0000, lower};
      end else if (avs_address_in == `MPR_OFS_PRESET) begin
        avs_readdata_out <= {16'h0000, preset};
      end else if (avs_address_in == `MPR_OFS_TRAVERSE) begin
        avs_readdata_out <= {19'h0, trav};
      end else if (avs_address_in == `MPR_OFS_OUTPUT) begin
        avs_readdata_out <= {16'h0000, out_val};
      end else if (avs_address_in == `MPR_OFS_STATUS) begin
        avs_readdata_out <= {28'h000_0000, mode == MPR_FORCE, ramping,
                             out_val <= lower, out_val >= upper};
      end else begin
        avs_readdata_out <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************
  // Setting registers, clamped on write
  // ****************************************************
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      upper <= `MPR_RST_UPPER;
      lower <= `MPR_RST_LOWER;
      preset <= `MPR_RST_PRESET;
    end else if (wr_go) begin
      if (avs_address_in == `MPR_OFS_UPPER) begin
        upper <= pct_clamp(lane_merge(upper, avs_writedata_in, avs_byteenable_in));
      end else if (avs_address_in == `MPR_OFS_LOWER) begin
        lower <= pct_clamp(lane_merge(lower, avs_writedata_in, avs_byteenable_in));
      end else if (avs_address_in == `MPR_OFS_PRESET) begin
        preset <= pct_clamp(lane_merge(preset, avs_writedata_in, avs_byteenable_in));
      end
    end
  end

  // Traverse time in tenths of a second, capped at 600.0 s
  logic [15:0] trav_wr;
  assign trav_wr = lane_merge({3'b000, trav}, avs_writedata_in, avs_byteenable_in);
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trav <= `MPR_RST_TRAVERSE;
    end else if (wr_go && avs_address_in == `MPR_OFS_TRAVERSE) begin
      if (trav_wr > 16'(`MPR_TRAV_MAX)) begin
        trav <= `MPR_TRAV_MAX;
      end else begin
        trav <= trav_wr[12:0];
      end
    end
  end

  // ****************************************************
  // Mode and target selection
  // ****************************************************
  // Limit-pull-back shares the target with a request so one path moves
  // the value; with lower above upper the pull-down to upper is checked first, as allowed
  always_comb begin
    if (force_in) begin
      mode = MPR_FORCE;
      target = preset;
    end else if (raise_in && !lower_in) begin
      mode = MPR_UP;
      target = upper;
    end else if (lower_in && !raise_in) begin
      mode = MPR_DOWN;
      target = lower;
    end else if (out_val > upper) begin
      mode = MPR_DOWN;
      target = upper;
    end else if (out_val < lower) begin
      mode = MPR_UP;
      target = lower;
    end else begin
      mode = MPR_HOLD;
      target = out_val;
    end
  end

  // ****************************************************
  // Step pacing: one hundredth per interval, so a full span of
  // 10000 hundredths takes exactly the traverse time
  // ****************************************************
  assign interval = CNT_W'(trav) * CNT_W'(STEP_CYC);
  assign ramping = (mode != MPR_FORCE) && (out_val != target) && !restore_pend;

  mpr_step #(
    .CNT_W(CNT_W)
  ) u_step (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(ramping && trav != '0),
    .interval_in(interval),
    .step_out(step)
  );

  // ****************************************************
  // Output value
  // ****************************************************
  always_comb begin
    if (restore_pend) begin
      next_out = pct_clamp(restore_value_in);
    end else if (mode == MPR_FORCE || trav == '0) begin
      next_out = target;
    end else if (step && out_val < target) begin
      next_out = out_val + 16'sd1;
    end else if (step && out_val > target) begin
      next_out = out_val - 16'sd1;
    end else begin
      next_out = out_val;
    end
  end

  // Reset leaves a constant; the retained value is loaded one edge later
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      restore_pend <= 1'b1;
      out_val <= 16'sd0;
      save_out <= 1'b0;
    end else begin
      restore_pend <= 1'b0;
      out_val <= next_out;
      // Restore load always saves, even when the retained value is zero
      save_out <= restore_pend || next_out != out_val;
    end
  end

  assign value_out = out_val;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  logic live;
  assign live = !restore_pend;

  force_track_a: assert property (live && force_in |=> out_val == $past(preset))
    else $error("output did not track preset");
  ramp_up_a: assert property (live && !force_in && raise_in && !lower_in
      && trav != '0 && step && out_val < upper |=> out_val == $past(out_val) + 16'sd1)
    else $error("up ramp step missing");
  ramp_down_a: assert property (live && !force_in && lower_in && !raise_in
      && trav != '0 && step && out_val > lower |=> out_val == $past(out_val) - 16'sd1)
    else $error("down ramp step missing");
  hold_idle_a: assert property (live && !force_in && raise_in == lower_in
      && out_val <= upper && out_val >= lower |=> $stable(out_val))
    else $error("output moved while holding");
  step_paced_a: assert property (live && !force_in && trav != '0 && !step
      |=> $stable(out_val))
    else $error("output moved without a step");
  over_upper_a: assert property (live && !force_in && raise_in == lower_in
      && trav != '0 && step && out_val > upper |=> out_val == $past(out_val) - 16'sd1)
    else $error("no pull-down to upper limit");
  under_lower_a: assert property (live && !force_in && raise_in == lower_in
      && trav != '0 && step && out_val < lower |=> out_val == $past(out_val) + 16'sd1)
    else $error("no pull-up to lower limit");
  restore_load_a: assert property (restore_pend
      |=> out_val == pct_clamp($past(restore_value_in)) && save_out)
    else $error("retained value not restored");
  span_clamp_a: assert property (upper <= `MPR_PCT_MAX && lower >= `MPR_PCT_MIN
      && preset <= `MPR_PCT_MAX && preset >= `MPR_PCT_MIN)
    else $error("setting outside span");
  zero_jump_a: assert property (live && trav == '0 |=> out_val == $past(target))
    else $error("zero traverse did not jump");
  bus_ack_a: assert property (access && !ack |=> !avs_waitrequest_out || !access)
    else $error("bus stalled more than one cycle");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("acknowledge held over two cycles");

  // Once at a limit, a lone request toward that limit leaves the output still
  top_hold_a: assert property (live && !force_in && raise_in && !lower_in
      && out_val == upper |=> $stable(out_val))
    else $error("output left upper limit");
  bottom_hold_a: assert property (live && !force_in && lower_in && !raise_in
      && out_val == lower |=> $stable(out_val))
    else $error("output left lower limit");
  // Every change of the output is offered to the store
  save_pulse_a: assert property (live |=> save_out == (out_val != $past(out_val)))
    else $error("save pulse out of step with output");

  // Main scenarios worth seeing reached
  up_ramp_c: cover property (live && mode == MPR_UP && step ##1 out_val == upper);
  down_ramp_c: cover property (live && mode == MPR_DOWN && step ##1 out_val == lower);
  pull_back_c: cover property (live && raise_in == lower_in && out_val > upper && step);
  force_c: cover property (force_in ##1 !force_in && raise_in);
  restore_c: cover property (restore_pend && restore_value_in != 16'h0000);

endmodule

// *** tb_motorised_pot_ramp.sv ***
// Self-checking bench for the motorised potentiometer ramp
`timescale 1ns/1ps
`include "mpr_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_motorised_pot_ramp;
  import mpr_pkg::*;
  // Short step interval keeps ramps within a quick run
  localparam int STEP = 2;
  localparam logic [15:0] RESTORE = 16'h0c35;
  logic core_clk_in, rst_in, raise_in, lower_in, force_in, rd, wr, save, wreq;
  logic [15:0] restore_value, value;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, got;
  logic signed [15:0] pv;
  int errors, n_checks, seed, k;

  mpr_top #(.STEP_CYC(STEP)) mpr_top_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .raise_in(raise_in), .lower_in(lower_in), .force_in(force_in),
    .restore_value_in(restore_value), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .value_out(value),
    .save_out(save));
  mpr_nv_store #(.INIT_VALUE(RESTORE)) mpr_nv_store_inst (.core_clk_in(core_clk_in),
    .save_in(save), .value_in(value), .restore_value_out(restore_value));

  // ****************************************
  // Clock, bus and ramp driving tasks
  // ****************************************
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  // Request held from just after an edge until the edge that sees waitrequest low;
  // read data taken at that edge, then released, so back-to-back calls leave one idle edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge core_clk_in);
    end while (wreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, got)
  endtask
  // Expected setting after a write: clamped to the allowed span
  function automatic logic [15:0] exp_clamp(input logic signed [15:0] v);
    if (v > `MPR_PCT_MAX) begin
      return `MPR_PCT_MAX;
    end
    if (v < `MPR_PCT_MIN) begin
      return `MPR_PCT_MIN;
    end
    return v;
  endfunction
  task automatic drive(input logic r, input logic l, input logic f, input int n);
    @(posedge core_clk_in);
    raise_in <= r;
    lower_in <= l;
    force_in <= f;
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  // Measures the spacing and size of two successive steps
  task automatic gap(input logic [15:0] dstep, input int trv);
    int t;
    int n;
    logic [15:0] v1;
    t = 0;
    n = 0;
    do begin @(negedge core_clk_in); t++; end while (!save && t < 20000);
    v1 = value;
    do begin @(negedge core_clk_in); n++; end while (!save && n < 20000);
    `CHK("step gap", trv * STEP, n)
    `CHK("step size", v1 + dstep, value)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'hbdd0;
    errors = 0;
    n_checks = 0;
    {raise_in, lower_in, force_in, rd, wr} = 5'h0;
    addr = 5'h0;
    wdata = 32'h0;
    rst_in = 1'b1;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    drive(1'b0, 1'b0, 1'b0, 1);
    `CHK("restored", RESTORE, value)
    rd_chk("upper", `MPR_OFS_UPPER, 32'h2710);
    rd_chk("lower", `MPR_OFS_LOWER, 32'hd8f0);
    rd_chk("preset", `MPR_OFS_PRESET, 32'h0);
    rd_chk("traverse", `MPR_OFS_TRAVERSE, 32'h64);
    rd_chk("unmapped", 5'h18, 32'h0);
    bus(1'b1, `MPR_OFS_UPPER, 32'h7918);
    rd_chk("upper clamp", `MPR_OFS_UPPER, 32'h7530);
    bus(1'b1, `MPR_OFS_LOWER, 32'h8000);
    rd_chk("lower clamp", `MPR_OFS_LOWER, 32'h8ad0);
    bus(1'b1, `MPR_OFS_TRAVERSE, 32'd7000);
    rd_chk("trav cap", `MPR_OFS_TRAVERSE, 32'd6000);
    bus(1'b1, `MPR_OFS_OUTPUT, 32'h5);
    rd_chk("output ro", `MPR_OFS_OUTPUT, {16'h0, RESTORE});
    // Random settings come back clamped to the span
    for (k = 0; k < 4; k++) begin
      pv = 16'($random(seed));
      bus(1'b1, `MPR_OFS_PRESET, {16'h0, pv});
      rd_chk("preset clamp", `MPR_OFS_PRESET, {16'h0, exp_clamp(pv)});
    end
    $display("test registers done");
    // Force tracks the preset whatever the requests say
    for (k = 0; k < 6; k++) begin
      pv = 16'($random(seed) % 30000);
      bus(1'b1, `MPR_OFS_PRESET, {16'h0, pv});
      drive(1'($random(seed)), 1'($random(seed)), 1'b1, 3);
      `CHK("forced", pv, value)
      rd_chk("status forced", `MPR_OFS_STATUS, 32'h8);
    end
    $display("test force done");
    // Zero traverse time jumps; limits kept in order by the far side
    bus(1'b1, `MPR_OFS_TRAVERSE, 32'h0);
    bus(1'b1, `MPR_OFS_UPPER, 32'd10);
    bus(1'b1, `MPR_OFS_LOWER, 32'hfff6);
    drive(1'b1, 1'b0, 1'b0, 3);
    `CHK("jump up", 16'd10, value)
    drive(1'b0, 1'b1, 1'b0, 3);
    `CHK("jump down", 16'hfff6, value)
    drive(1'b1, 1'b1, 1'b0, 10);
    `CHK("both hold", 16'hfff6, value)
    drive(1'b0, 1'b0, 1'b0, 10);
    `CHK("none hold", 16'hfff6, value)
    bus(1'b1, `MPR_OFS_LOWER, 32'hffe2);
    bus(1'b1, `MPR_OFS_UPPER, 32'hfff1);
    drive(1'b0, 1'b0, 1'b0, 3);
    `CHK("pull to upper", 16'hfff1, value)
    bus(1'b1, `MPR_OFS_UPPER, 32'd100);
    bus(1'b1, `MPR_OFS_LOWER, 32'd50);
    drive(1'b1, 1'b1, 1'b0, 3);
    `CHK("pull to lower", 16'd50, value)
    $display("test limits done");
    // Rate: same spacing both ways, one hundredth per step
    bus(1'b1, `MPR_OFS_LOWER, 32'hff9c);
    bus(1'b1, `MPR_OFS_TRAVERSE, 32'd3);
    drive(1'b1, 1'b0, 1'b0, 0);
    gap(16'h0001, 3);
    drive(1'b0, 1'b1, 1'b0, 0);
    gap(16'hffff, 3);
    bus(1'b1, `MPR_OFS_TRAVERSE, 32'd1);
    drive(1'b1, 1'b0, 1'b0, 300);
    `CHK("stop at upper", 16'd100, value)
    rd_chk("status upper", `MPR_OFS_STATUS, 32'h1);
    $display("test rate done");
    // Reset in mid-run resumes from the stored value
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    drive(1'b0, 1'b0, 1'b0, 1);
    `CHK("resumed", 16'd100, value)
    $display("test persistence done");
    conclude();
  end
endmodule
